/* File: mfr_framer.sv */
// Media slot and control packet framer for one network port.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Octets 42..169 carry thirty-two slot words.
// - Word before slots flags each valid slot.
// - Single rate maps one slot per channel.
// - Double rate gives channel n slots 2n,2n+1.
// - Quad rate groups four ascending slots.
// - Map table allows any slot count.
// - Later samples of a channel use higher slots.
// - Receiver accepts any channel interleaving.
// - Short samples left-justified, low bits zeroed.
// - One audio sample per slot word advised.
// - Non-audio bits sit at word low end.
// - Control packet octets 174..217, header then payload.
// - Twelve-bit type code in octets 174..175.
// - Code high nibble in 174 low bits.
// - Twelve-bit length in octets 176..177.
// - Spare nibble of 176 sent zero, ignored.
// - Unit then component addresses, octets 178..185.
// - Status: send-ok 7, valid 5, start 4.
// - Without valid only clear-to-send is honoured.
// - Clear-to-send belongs to this port.
// - Peer clear-to-send low stops packet issue.
// - Lower clear-to-send with eight queue places free.
// - Paused frames still sent, valid clear.
// - Resume when peer clear-to-send returns.
// - Flow control per port, both directions.
// - First packet of each message flags start.
module mfr_framer #(
	parameter int QDEPTH = 16 // Places in the receive packet queue.
) (
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic              tx_step,
	input  wire logic [7:0]        tx_pos,
	output logic      [7:0]        tx_data,
	output logic                   tx_own,
	input  wire logic [31:0]       tx_slot_mask,
	output logic                   tx_slot_req,
	output mfr_pkg::mfr_slot_t     tx_slot,
	input  wire logic [31:0]       tx_sample,
	input  wire logic [5:0]        tx_res,
	input  wire logic [31:0]       tx_aux,
	input  wire logic [5:0]        tx_aux_bits,
	input  wire logic              tx_ctl_valid,
	input  wire mfr_pkg::mfr_pkt_t tx_ctl_pkt,
	output logic                   tx_ctl_take,
	input  wire logic              rx_step,
	input  wire logic [7:0]        rx_pos,
	input  wire logic [7:0]        rx_octet,
	output logic                   rx_slot_vld,
	output mfr_pkg::mfr_rxs_t      rx_slot,
	output logic                   rx_pkt_vld,
	output mfr_pkg::mfr_pkt_t      rx_pkt,
	output logic                   rx_first,
	output logic                   rx_last,
	output logic      [5:0]        rx_count,
	input  wire logic              rx_ctl_pop
);
	// -------------------------------------------------------------
	// Helper functions.
	// -------------------------------------------------------------
	// Channel of a slot: default rate map or the software table.
	function automatic logic [4:0] slot_ch(input logic [4:0] slot,
		input logic [3:0] ctrl, input logic [4:0] tch);
		if (ctrl[mfr_pkg::CTRL_TAB]) begin
			return tch;
		end
		return slot >> ctrl[2:0];
	endfunction

	// Mask with the low n bits set.
	function automatic logic [31:0] low_mask(input logic [5:0] n);
		if (n >= 6'h20) begin
			return 32'hFFFFFFFF;
		end
		return (32'h00000001 << n) - 32'h00000001;
	endfunction

	// Octets of a message that one packet carries.
	function automatic logic [5:0] chunk(input logic [11:0] n);
		return (n > mfr_pkg::LEN_PAY) ? 6'h20 : n[5:0];
	endfunction

	// -------------------------------------------------------------
	// Registers and state.
	// -------------------------------------------------------------
	logic [3:0]         ctrl_q;     // Rate in [2:0], table in [3].
	logic [7:0]         occ_q;      // Receive queue occupancy.
	logic               peer_cts_q; // Clear to send from the neighbour.
	logic               send_q;     // This frame carries a packet.
	logic               start_q;    // This packet starts a message.
	mfr_pkg::mfr_pkt_t  pkt_q;      // Packet held for this frame.
	mfr_pkg::mfr_msg_t  msg_q;      // Outgoing message progress.
	logic [11:0]        rem_q;      // Outgoing octets still to send.
	logic [31:0]        word_q;     // Next outgoing slot word.
	logic               wait_q;     // Slot word arrives this cycle.
	logic [31:0]        rmask_q;    // Incoming slot valid word.
	logic [23:0]        rword_q;    // Incoming slot word so far.
	logic [343:0]       rctl_q;     // Incoming control octets so far.
	mfr_pkg::mfr_msg_t  rmsg_q;     // Incoming message progress.
	logic [11:0]        rrem_q;     // Incoming octets still due.

	// -------------------------------------------------------------
	// Transmit position decode.
	// -------------------------------------------------------------
	wire logic [7:0] sub_m   = tx_pos - mfr_pkg::POS_MASK;
	wire logic [7:0] sub_s   = tx_pos - mfr_pkg::POS_SLOT0;
	wire logic [7:0] sub_c   = tx_pos - mfr_pkg::POS_CTL;
	wire logic       in_mask = tx_pos >= mfr_pkg::POS_MASK &&
		tx_pos < mfr_pkg::POS_SLOT0;
	wire logic       in_slot = tx_pos >= mfr_pkg::POS_SLOT0 &&
		tx_pos <= mfr_pkg::POS_SLOT_END;
	wire logic       in_ctl  = tx_pos >= mfr_pkg::POS_CTL &&
		tx_pos <= mfr_pkg::POS_CTL_END;
	wire logic       in_req  = tx_pos >= mfr_pkg::POS_MASK &&
		tx_pos <= mfr_pkg::POS_REQ_END && sub_m[1:0] == 2'h3;
	wire logic       tx_sof  = tx_step && tx_pos == mfr_pkg::POS_FRAME;

	// -------------------------------------------------------------
	// Flow control decode.
	// -------------------------------------------------------------
	// Own clear to send drops while only the reserve is left.
	wire logic local_cts = (8'(QDEPTH) - occ_q) > mfr_pkg::CTS_RESERVE;
	wire logic issue     = tx_sof && tx_ctl_valid && peer_cts_q;

	// -------------------------------------------------------------
	// Slot mapping, shared table.
	// -------------------------------------------------------------
	logic [4:0] tch_tx; // Table entry for the slot requested.
	logic [4:0] tch_rx; // Table entry for the slot received.
	logic [4:0] tch_rd; // Table entry for a register read.
	logic [4:0] seq_tx; // Order of the requested sample.
	logic [4:0] seq_rx; // Order of the received sample.
	wire logic [7:0] rsub_m = rx_pos - mfr_pkg::POS_MASK;
	wire logic [7:0] rsub_s = rx_pos - mfr_pkg::POS_SLOT0;
	wire logic [4:0] ch_tx  = slot_ch(sub_m[6:2], ctrl_q, tch_tx);
	wire logic [4:0] ch_rx  = slot_ch(rsub_s[6:2], ctrl_q, tch_rx);
	wire logic map_we = reg_wr && reg_addr[7] && reg_addr[1:0] == 2'h0;

	mfr_slot_map u_map (
		.mclk  (mclk),
		.rst_b (rst_b),
		.we    (map_we),
		.waddr (reg_addr[6:2]),
		.wdata (reg_wdata[4:0]),
		.ra    (sub_m[6:2]),
		.rb    (rsub_s[6:2]),
		.rc    (reg_addr[6:2]),
		.qa    (tch_tx),
		.qb    (tch_rx),
		.qc    (tch_rd)
	);

	// Sample order per channel keeps later samples in later slots.
	mfr_order u_tx_order (
		.mclk  (mclk),
		.rst_b (rst_b),
		.clr   (tx_sof),
		.step  (tx_step && in_req),
		.ch    (ch_tx),
		.seq   (seq_tx)
	);

	// -------------------------------------------------------------
	// Transmit octet selection.
	// -------------------------------------------------------------
	// Short samples sit at the top; status bits take the low end.
	wire logic [5:0]  shamt  = 6'h20 - tx_res;
	wire logic [31:0] word_d = (tx_sample << shamt) |
		(tx_aux & low_mask(tx_aux_bits));
	wire logic [3:0]  code_hi = send_q ? pkt_q.hdr.code[11:8] : 4'h0;
	wire logic [7:0]  st_oct = {local_cts, 1'b0, send_q,
		send_q && start_q, code_hi};
	wire logic [343:0] body = {pkt_q.hdr.code[7:0], 4'h0,
		pkt_q.hdr.len, pkt_q.hdr.dst_unit, pkt_q.hdr.src_unit,
		pkt_q.hdr.dst_comp, pkt_q.hdr.src_comp, pkt_q.data};
	wire logic [351:0] ctl_vec = {st_oct, send_q ? body : 344'h0};
	wire logic [351:0] ctl_sh  = ctl_vec << {sub_c[5:0], 3'h0};
	wire logic [31:0]  mask_sh = tx_slot_mask << {sub_m[1:0], 3'h0};
	wire logic [31:0]  word_sh = word_q << {sub_s[1:0], 3'h0};
	wire logic [7:0]   oct_d = in_mask ? mask_sh[31:24] :
		in_slot ? word_sh[31:24] :
		in_ctl ? ctl_sh[351:344] : 8'h00;

	// Octet output follows each position step by one cycle.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_data <= 8'h00;
			tx_own  <= 1'b0;
		end else if (tx_step) begin
			tx_data <= oct_d;
			tx_own  <= in_mask || in_slot || in_ctl;
		end
	end

	// A slot word is asked for on the octet before it goes out, so the
	// word being sent is never replaced in the middle of its slot while steps come at most every other cycle.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_slot_req <= 1'b0;
			tx_slot     <= '0;
			wait_q      <= 1'b0;
			word_q      <= 32'h00000000;
		end else begin
			tx_slot_req <= tx_step && in_req;
			wait_q      <= tx_step && in_req;
			if (tx_step && in_req) begin
				tx_slot <= '{idx: sub_m[6:2], ch: ch_tx, seq: seq_tx};
			end
			if (wait_q) begin
				word_q <= word_d;
			end
		end
	end

	// -------------------------------------------------------------
	// Outgoing packet issue and message progress.
	// -------------------------------------------------------------
	// Decided once per frame; a paused frame still goes out.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			send_q      <= 1'b0;
			start_q     <= 1'b0;
			pkt_q       <= '0;
			msg_q       <= mfr_pkg::MSG_IDLE;
			rem_q       <= 12'h000;
			tx_ctl_take <= 1'b0;
		end else begin
			tx_ctl_take <= issue;
			if (tx_sof) begin
				send_q <= issue;
			end
			if (issue) begin
				pkt_q <= tx_ctl_pkt;
				unique case (msg_q)
					// A new message always opens with the start flag.
					mfr_pkg::MSG_IDLE: begin
						start_q <= 1'b1;
						if (tx_ctl_pkt.hdr.len > mfr_pkg::LEN_PAY) begin
							rem_q <= tx_ctl_pkt.hdr.len - mfr_pkg::LEN_PAY;
							msg_q <= mfr_pkg::MSG_MORE;
						end
					end
					// Continuations run until the length is used up.
					mfr_pkg::MSG_MORE: begin
						start_q <= 1'b0;
						if (rem_q > mfr_pkg::LEN_PAY) begin
							rem_q <= rem_q - mfr_pkg::LEN_PAY;
						end else begin
							rem_q <= 12'h000;
							msg_q <= mfr_pkg::MSG_IDLE;
						end
					end
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Receive side.
	// -------------------------------------------------------------
	wire logic r_mask = rx_pos >= mfr_pkg::POS_MASK &&
		rx_pos < mfr_pkg::POS_SLOT0;
	wire logic r_slot = rx_pos >= mfr_pkg::POS_SLOT0 &&
		rx_pos <= mfr_pkg::POS_SLOT_END;
	wire logic r_ctl  = rx_pos >= mfr_pkg::POS_CTL &&
		rx_pos <= mfr_pkg::POS_CTL_END;
	wire logic r_emit = rx_step && r_slot && rsub_s[1:0] == 2'h3;
	wire logic r_sof  = rx_step && rx_pos == mfr_pkg::POS_FRAME;
	wire logic [351:0] full = {rctl_q, rx_octet};
	// Only the status octet is trusted unless the valid flag is set.
	wire logic r_done = rx_step && rx_pos == mfr_pkg::POS_CTL_END &&
		full[344 + mfr_pkg::BIT_VALID];
	wire logic        r_start = full[344 + mfr_pkg::BIT_START];
	wire logic [11:0] r_len = {full[331:328], full[327:320]};
	// A continuation with no open message is taken as a lone piece.
	wire logic [11:0] r_n = r_start ? r_len :
		(rmsg_q == mfr_pkg::MSG_MORE) ? rrem_q : mfr_pkg::LEN_PAY;
	wire logic        r_end = r_n <= mfr_pkg::LEN_PAY;

	mfr_order u_rx_order (
		.mclk  (mclk),
		.rst_b (rst_b),
		.clr   (r_sof),
		.step  (r_emit),
		.ch    (ch_rx),
		.seq   (seq_rx)
	);

	// Slot words are gathered octet by octet, top octet first.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rmask_q     <= 32'h00000000;
			rword_q     <= 24'h000000;
			rctl_q      <= '0;
			rx_slot_vld <= 1'b0;
			rx_slot     <= '0;
		end else begin
			rx_slot_vld <= r_emit;
			if (rx_step && r_mask) begin
				rmask_q <= {rmask_q[23:0], rx_octet};
			end
			if (rx_step && r_slot) begin
				rword_q <= {rword_q[15:0], rx_octet};
			end
			if (rx_step && r_ctl) begin
				rctl_q <= {rctl_q[335:0], rx_octet};
			end
			if (r_emit) begin
				rx_slot.tag  <= '{idx: rsub_s[6:2], ch: ch_rx, seq: seq_rx};
				rx_slot.ok   <= rmask_q[rsub_s[6:2]];
				rx_slot.data <= {rword_q, rx_octet};
			end
		end
	end

	// Neighbour clear to send is taken from every frame.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			peer_cts_q <= 1'b0;
		end else if (rx_step && rx_pos == mfr_pkg::POS_CTL) begin
			peer_cts_q <= rx_octet[mfr_pkg::BIT_CTS];
		end
	end

	// Packet delivery and reassembly by start flag and length.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rx_pkt_vld <= 1'b0;
			rx_pkt     <= '0;
			rx_first   <= 1'b0;
			rx_last    <= 1'b0;
			rx_count   <= 6'h00;
			rmsg_q     <= mfr_pkg::MSG_IDLE;
			rrem_q     <= 12'h000;
		end else begin
			rx_pkt_vld <= r_done;
			if (r_done) begin
				rx_pkt <= '{hdr: '{code: {full[347:344], full[343:336]},
					len: r_len, dst_unit: full[319:304],
					src_unit: full[303:288], dst_comp: full[287:272],
					src_comp: full[271:256]}, data: full[255:0]};
				rx_first <= r_start;
				rx_last  <= r_end;
				rx_count <= chunk(r_n);
				rmsg_q   <= r_end ? mfr_pkg::MSG_IDLE : mfr_pkg::MSG_MORE;
				rrem_q   <= r_end ? 12'h000 : r_n - mfr_pkg::LEN_PAY;
			end
		end
	end

	// Queue occupancy; the user pops each packet it has taken.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			occ_q <= 8'h00;
		end else if (r_done && !(rx_ctl_pop && occ_q != 8'h00)) begin
			occ_q <= (occ_q < 8'(QDEPTH)) ? occ_q + 8'h01 : occ_q;
		end else if (!r_done && rx_ctl_pop && occ_q != 8'h00) begin
			occ_q <= occ_q - 8'h01;
		end
	end

	// -------------------------------------------------------------
	// Register port.
	// -------------------------------------------------------------
	wire logic [31:0] status = {16'h0000, occ_q, 6'h00,
		local_cts, peer_cts_q};
	wire logic map_we_rd = reg_addr[7] && reg_addr[1:0] == 2'h0;
	wire logic [31:0] rd_mux =
		(reg_addr == mfr_pkg::REG_CTRL) ? {28'h0000000, ctrl_q} :
		(reg_addr == mfr_pkg::REG_STATUS) ? status :
		map_we_rd ? {27'h0000000, tch_rd} : 32'h00000000;

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_q    <= mfr_pkg::CTRL_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
			if (reg_wr && reg_addr == mfr_pkg::REG_CTRL) begin
				ctrl_q <= reg_wdata[3:0];
			end
		end
	end

	// -------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	chk_cts_stop: assert property (
		tx_ctl_take |-> $past(peer_cts_q))
		else $error("packet issued while peer not clear");
	chk_pause_valid: assert property (
		(tx_step && tx_pos == mfr_pkg::POS_CTL && !send_q)
		|=> tx_own && !tx_data[mfr_pkg::BIT_VALID])
		else $error("paused frame shows packet valid");
	chk_status_rsv: assert property (
		(tx_step && tx_pos == mfr_pkg::POS_CTL)
		|=> !tx_data[mfr_pkg::BIT_RSV] && tx_data[7] == $past(local_cts))
		else $error("status octet wrong");
	chk_len_spare: assert property (
		(tx_step && tx_pos == mfr_pkg::POS_LEN) |=> tx_data[7:4] == 4'h0)
		else $error("length spare bits not zero");
	chk_left_just: assert property (
		(tx_slot_req && tx_res == 6'h18 && tx_aux_bits <= 6'h08)
		|=> word_q[31:8] == $past(tx_sample[23:0]) &&
		(word_q[7:0] & ~$past(tx_aux[7:0])) == 8'h00)
		else $error("sample not left justified");
	chk_cts_room: assert property (
		$fell(local_cts) |-> (8'(QDEPTH) - occ_q) >= mfr_pkg::CTS_RESERVE)
		else $error("clear to send lowered too late");
	chk_msg_first: assert property (
		(issue && msg_q == mfr_pkg::MSG_IDLE) |=> start_q && tx_ctl_take)
		else $error("message start flag missing");
	chk_msg_cont: assert property (
		(issue && msg_q == mfr_pkg::MSG_MORE) |=> !start_q ##1 !tx_ctl_take)
		else $error("continuation flagged as start");
	chk_peer_cts: assert property (
		(rx_step && rx_pos == mfr_pkg::POS_CTL)
		|=> peer_cts_q == $past(rx_octet[mfr_pkg::BIT_CTS]))
		else $error("peer clear to send not taken");
	cov_issue: cover property (tx_ctl_take ##[1:300] tx_ctl_take);
	cov_pause: cover property ($fell(peer_cts_q) ##[1:1000] $rose(peer_cts_q));
	cov_multi: cover property (rx_pkt_vld && !rx_first && rx_last);
endmodule // mfr_framer
`default_nettype wire

/* File: mfr_pkg.sv */
// Shared constants and carrier types for the media slot and control framer.
`default_nettype none
package mfr_pkg;
	// -------------------------------------------------------------
	// Frame octet positions.
	// -------------------------------------------------------------
	localparam logic [7:0] POS_FRAME   = 8'h00; // First octet of a frame.
	localparam logic [7:0] POS_MASK    = 8'h26; // Slot valid word, 38.
	localparam logic [7:0] POS_SLOT0   = 8'h2A; // Slot 0 first octet, 42.
	localparam logic [7:0] POS_REQ_END = 8'hA5; // Last slot request, 165.
	localparam logic [7:0] POS_SLOT_END = 8'hA9; // Slot 31 last octet, 169.
	localparam logic [7:0] POS_CTL     = 8'hAE; // Status octet, 174.
	localparam logic [7:0] POS_LEN     = 8'hB0; // Length high octet, 176.
	localparam logic [7:0] POS_CTL_END = 8'hD9; // Last payload octet, 217.
	// -------------------------------------------------------------
	// Status octet bit positions and packet sizes.
	// -------------------------------------------------------------
	localparam int unsigned BIT_CTS   = 32'h7; // Clear to send.
	localparam int unsigned BIT_RSV   = 32'h6; // Reserved, sent zero.
	localparam int unsigned BIT_VALID = 32'h5; // Packet valid flag.
	localparam int unsigned BIT_START = 32'h4; // Message start flag.
	localparam logic [11:0] LEN_PAY   = 12'h020; // Payload octets.
	localparam logic [7:0]  CTS_RESERVE = 8'h08; // Queue room kept.
	// -------------------------------------------------------------
	// Register map and reset values.
	// -------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00; // Rate and table select.
	localparam logic [7:0] REG_STATUS = 8'h04; // Flow and queue state.
	localparam logic [7:0] REG_MAP    = 8'h80; // Slot map, one per word.
	localparam logic [3:0] CTRL_RESET = 4'h0; // Single rate, no table.
	localparam int unsigned CTRL_TAB  = 32'h3; // Table select bit.
	// -------------------------------------------------------------
	// Carrier types.
	// -------------------------------------------------------------
	typedef struct packed {
		logic [11:0] code;     // Message type code.
		logic [11:0] len;      // Message length in octets.
		logic [15:0] dst_unit; // Destination unit address.
		logic [15:0] src_unit; // Source unit address.
		logic [15:0] dst_comp; // Destination component address.
		logic [15:0] src_comp; // Source component address.
	} mfr_hdr_t;
	typedef struct packed {
		mfr_hdr_t     hdr;  // Eleven-octet header fields.
		logic [255:0] data; // Payload, first octet in the top bits.
	} mfr_pkt_t;
	typedef struct packed {
		logic [4:0] idx; // Slot number.
		logic [4:0] ch;  // Channel mapped to the slot.
		logic [4:0] seq; // Sample order of the channel in this frame.
	} mfr_slot_t;
	typedef struct packed {
		mfr_slot_t   tag;  // Slot identity.
		logic        ok;   // Slot valid flag from the frame.
		logic [31:0] data; // Slot word.
	} mfr_rxs_t;
	typedef enum logic [0:0] {MSG_IDLE, MSG_MORE} mfr_msg_t;
endpackage
`default_nettype wire

/* File: mfr_slot_map.sv */
// Slot to channel table, writable, with three read ports.
`timescale 1ns/1ps
`default_nettype none
module mfr_slot_map (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       we,
	input  wire logic [4:0] waddr,
	input  wire logic [4:0] wdata,
	input  wire logic [4:0] ra,
	input  wire logic [4:0] rb,
	input  wire logic [4:0] rc,
	output logic      [4:0] qa,
	output logic      [4:0] qb,
	output logic      [4:0] qc
);
	// -------------------------------------------------------------
	// Table storage.
	// -------------------------------------------------------------
	logic [4:0] map_q [32]; // Channel number per slot.

	// Reads are combinational so lookups cost no latency.
	assign qa = map_q[ra];
	assign qb = map_q[rb];
	assign qc = map_q[rc];

	// Reset gives the identity map; writes replace one entry.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			for (int i = 0; i < 32; i++) begin
				map_q[i] <= 5'(i);
			end
		end else if (we) begin
			map_q[waddr] <= wdata;
		end
	end
endmodule // mfr_slot_map
`default_nettype wire

/* File: mfr_order.sv */
// Per-channel sample order counters, cleared at each frame start.
`timescale 1ns/1ps
`default_nettype none
module mfr_order (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       clr,
	input  wire logic       step,
	input  wire logic [4:0] ch,
	output logic      [4:0] seq
);
	// -------------------------------------------------------------
	// Counters.
	// -------------------------------------------------------------
	logic [4:0] cnt_q [32]; // Samples of each channel seen so far.

	// Order of the sample now being placed, before counting it.
	assign seq = cnt_q[ch];

	// Clearing wins over a step, since a new frame starts at zero.
	always_ff @(posedge mclk) begin
		if (!rst_b || clr) begin
			for (int i = 0; i < 32; i++) begin
				cnt_q[i] <= 5'h00;
			end
		end else if (step) begin
			cnt_q[ch] <= cnt_q[ch] + 5'h01;
		end
	end
endmodule // mfr_order
`default_nettype wire

/* File: mfr_peer.sv */
// Neighbour port model that sends frames of octets into the framer.
`timescale 1ns/1ps
`default_nettype none
module mfr_peer (
	output logic       rx_step,
	output logic [7:0] rx_pos,
	output logic [7:0] rx_octet,
	input  wire logic  mclk
);
	// Control section, status nibble first, then header and payload.
	logic [351:0] sec;
	initial begin
		rx_step = 1'b0;
		rx_pos = 8'h00;
		rx_octet = 8'h00;
	end
	// One frame; idle octets toggle so a stale value never looks valid.
	task automatic send(input logic cts, input logic vld,
		input mfr_pkg::mfr_pkt_t p);
		sec = {cts, 1'b0, vld, 1'b1, p.hdr.code, 4'h0, p.hdr.len,
			p.hdr.dst_unit, p.hdr.src_unit, p.hdr.dst_comp, p.hdr.src_comp,
			p.data};
		for (int i = 0; i < 218; i++) begin
			@(posedge mclk);
			rx_step <= 1'b1;
			rx_pos <= 8'(i);
			rx_octet <= (i < 174) ? 8'(i) ^ 8'hA5 : sec[351 - 8 * (i - 174) -: 8];
			@(posedge mclk);
			rx_step <= 1'b0;
			rx_octet <= ~rx_octet;
		end
	endtask
endmodule // mfr_peer
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the framer beside a neighbour model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0, rst_b, reg_wr, reg_rd, tx_step, tx_own, rd_q;
	logic        tx_slot_req, tx_ctl_valid, tx_ctl_take, rx_step, watch_q;
	logic        rx_slot_vld, rx_pkt_vld, rx_first, rx_last, rx_ctl_pop;
	logic [7:0]  reg_addr, tx_pos, tx_data, rx_pos, rx_octet;
	logic [31:0] reg_wdata, reg_rdata, tx_slot_mask, tx_sample, tx_aux;
	logic [31:0] seed = 32'h505E;
	logic [5:0]  tx_res, tx_aux_bits, rx_count;
	logic [31:0] q[$];
	int          failures, n_compared;
	mfr_pkg::mfr_slot_t tx_slot;
	mfr_pkg::mfr_rxs_t  rx_slot;
	mfr_pkg::mfr_pkt_t  tx_ctl_pkt, rx_pkt, pk;
	// Nine queue places make own clear to send drop after one packet.
	mfr_framer #(.QDEPTH(9)) dut (.mclk, .rst_b, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .tx_step, .tx_pos, .tx_data, .tx_own,
		.tx_slot_mask, .tx_slot_req, .tx_slot, .tx_sample, .tx_res, .tx_aux,
		.tx_aux_bits, .tx_ctl_valid, .tx_ctl_pkt, .tx_ctl_take, .rx_step,
		.rx_pos, .rx_octet, .rx_slot_vld, .rx_slot, .rx_pkt_vld, .rx_pkt,
		.rx_first, .rx_last, .rx_count, .rx_ctl_pop);
	mfr_peer peer (.mclk, .rx_step, .rx_pos, .rx_octet);
	always #5 mclk = ~mclk;
	// Xorshift source, so runs repeat exactly.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Takes the oldest note and compares it with what was seen.
	task automatic chk(input string nm, input logic [31:0] seen);
		logic [31:0] e;
		e = q.pop_front();
		n_compared++;
		if (seen !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask
	// One register access; a read notes its expected data.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		if (w) reg_wr <= 1'b1;
		else begin
			reg_rd <= 1'b1;
			q.push_back(d);
		end
		@(posedge mclk);
		{reg_wr, reg_rd} <= 2'h0;
	endtask
	// Sends one outgoing frame; slot 0 holds a 24-bit sample and 4 aux bits.
	task automatic frame(input logic [7:0] st, input logic tk,
		input logic [4:0] ch);
		logic [31:0] s, a;
		s = xs();
		a = xs();
		tx_slot_mask <= s | 32'h1;
		tx_sample <= s & 32'hFFFFFF;
		tx_aux <= a & 32'hF;
		if (tk) q.push_back(32'h1);
		q.push_back({24'h0, s[31:24]});
		q.push_back({24'h0, s[23:16]});
		q.push_back({28'h0, a[3:0]});
		q.push_back({17'h0, 5'h5, ch, 5'h1});
		q.push_back({24'h0, st});
		for (int i = 0; i < 218; i++) begin
			@(posedge mclk);
			tx_step <= 1'b1;
			tx_pos <= 8'(i);
			@(posedge mclk);
			tx_step <= 1'b0;
		end
	endtask
	// Sends one incoming frame and notes what slot 5 and the packet give.
	task automatic rx_frame(input logic cts, input logic vld);
		q.push_back({16'h0, 5'h5, 5'h5, 5'h1, 1'b0});
		q.push_back({8'h3E, 8'h3F, 8'h40, 8'h41} ^ 32'hA5A5A5A5);
		if (vld) begin
			q.push_back({6'h14, 1'b1, 1'b1, 12'h2A7, 12'h014});
			q.push_back(pk.data[31:0]);
		end
		peer.send(cts, vld, pk);
	endtask
	// Watches outputs at each edge and checks results in order.
	always @(posedge mclk) begin
		rd_q <= reg_rd;
		watch_q <= tx_step && (tx_pos inside {8'h26, 8'h2A, 8'h2D, 8'hAE});
		if (rd_q) chk("reg_rdata", reg_rdata);
		if (tx_ctl_take) chk("tx_ctl_take", 32'h1);
		if (watch_q) chk("tx_data", {24'h0, tx_data});
		if (tx_slot_req && tx_slot.idx == 5'h5) begin
			chk("tx_slot", {17'h0, tx_slot});
		end
		if (rx_slot_vld && rx_slot.tag.idx == 5'h5) begin
			chk("rx_slot_tag", {16'h0, rx_slot.tag, rx_slot.ok});
			chk("rx_slot_data", rx_slot.data);
		end
		if (rx_pkt_vld) begin
			chk("rx_hdr", {rx_count, rx_first, rx_last, rx_pkt.hdr.code, rx_pkt.hdr.len});
			chk("rx_data", rx_pkt.data[31:0]);
		end
	end
	task automatic final_report();
		if (q.size() != 0) failures++;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		{rst_b, reg_wr, reg_rd, tx_step, tx_ctl_valid, rx_ctl_pop} = '0;
		{reg_addr, tx_pos, reg_wdata, tx_slot_mask, tx_sample, tx_aux} = '0;
		{tx_res, tx_aux_bits, tx_ctl_pkt} = {6'h18, 6'h4, 344'h0};
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		acc(0, 8'h84, 32'h1);
		acc(1, 8'h84, 32'h5);
		acc(0, 8'h84, 32'h5);
		acc(0, 8'h40, 32'h0);
		acc(1, 8'h00, 32'h8);
		acc(0, 8'h00, 32'h8);
		$display("test registers done");
		pk = {12'h2A7, 12'h014, 64'h0123456789ABCDEF, xs(), xs(), xs(), xs(),
			xs(), xs(), xs(), xs()};
		rx_frame(1'b1, 1'b1);
		acc(0, 8'h04, 32'h101);
		$display("test receive done");
		pk.hdr.len = 12'h028;
		tx_ctl_pkt <= pk;
		tx_ctl_valid <= 1'b1;
		frame(8'h32, 1'b1, 5'h5);
		frame(8'h22, 1'b1, 5'h5);
		rx_frame(1'b0, 1'b0);
		acc(0, 8'h04, 32'h100);
		@(posedge mclk) rx_ctl_pop <= 1'b1;
		@(posedge mclk) rx_ctl_pop <= 1'b0;
		acc(0, 8'h04, 32'h002);
		acc(1, 8'h00, 32'h1);
		frame(8'h80, 1'b0, 5'h2);
		$display("test transmit done");
		final_report();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		final_report();
	end
endmodule // tb_top
`default_nettype wire
